// ==== frbc_pkg.sv ====
// Purpose: Shared constants and types of the flash read buffer controller
// Assumes: APB register bus, 32-bit AHB data port, 128-bit flash word
// Notes:   Register offsets are byte addresses
package frbc_pkg;
  // ************************
  // Register map
  // ************************
  localparam logic [11:0] FRBC_CFG_OFS    = 12'h000;
  localparam logic [11:0] FRBC_STATUS_OFS = 12'h004;
  localparam logic [11:0] FRBC_CMD_OFS    = 12'h008;
  localparam logic [11:0] FRBC_SECURE_OFS = 12'h00c;
  localparam logic [11:0] FRBC_LATCH_OFS  = 12'h010;
  // Config fields
  localparam int CFG_MODE_LSB  = 0;
  localparam int CFG_ASYNC_BIT = 2;
  localparam int CFG_ISS_BIT   = 3;
  localparam int CFG_WST_LSB   = 4;
  // Status fields
  localparam int ST_INIT_BIT   = 0;
  localparam int ST_PROT_BIT   = 1;
  localparam int ST_BURN_BIT   = 2;
  localparam int ST_ERASE_BIT  = 3;
  localparam int ST_SPEC_BIT   = 4;
  // Command fields
  localparam int CMD_BURN_BIT  = 0;
  localparam int CMD_ERASE_BIT = 1;
  // Buffer modes
  localparam logic [1:0] MODE_NONE   = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_DUAL1  = 2'h2;
  localparam logic [1:0] MODE_ALWAYS = 2'h3;
  // Reset values: sync timing, single line, slowest wait count
  localparam logic [1:0] MODE_RESET  = MODE_SINGLE;
  localparam logic [3:0] WST_RESET   = 4'hf;
  localparam logic [3:0] INIT_WST    = 4'hf;
  // Flash word geometry and index word layout
  localparam int WORD_LSB       = 4;
  localparam int TAG_W          = 28;
  localparam logic [TAG_W-1:0] TAG_ONE   = 28'h0000001;
  localparam logic [TAG_W-1:0] INDEX_TAG = 28'h0000000;
  localparam int JTAG_PROT_BIT  = 0;
  localparam int SEC_MASK_LSB   = 16;
  localparam int SEC_REGION_LSB = 16;
  localparam logic HRESP_OKAY   = 1'b0;

  typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_DEMAND, ST_SPEC} frbc_state_t;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic        hready;
    logic [31:0] hwdata;
  } frbc_ahb_req_t;

  typedef struct packed {
    logic             rd;
    logic [TAG_W-1:0] tag;
    logic             index_sel;
    logic             standby;
    logic             burn_start;
    logic             erase_start;
    logic [127:0]     wdata;
  } frbc_flash_req_t;

  typedef struct packed {
    logic [127:0] rdata;
    logic         burn_done;
    logic         erase_done;
  } frbc_flash_rsp_t;
endpackage : frbc_pkg

// ==== frbc.sv ====
// Purpose: Flash read buffer controller, AHB data port to 128-bit flash
// Assumes: Flash data valid after wait count + 1 cycles of a held read
// Notes:   Configuration, command and status over APB
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps

module frbc
  import frbc_pkg::*;
(
  // Clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // APB register port
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  // AHB data port
  input  frbc_pkg::frbc_ahb_req_t        ahb,
  output logic [31:0]                    hrdata,
  output logic                           hreadyout,
  output logic                           hresp,
  // Flash array
  output frbc_pkg::frbc_flash_req_t      flash_req,
  input  frbc_pkg::frbc_flash_rsp_t      flash_rsp,
  // JTAG access and debug
  input  wire logic                      jtag_req,
  output logic                           jtag_grant,
  output logic                           debug_en,
  // Events
  output logic                           burn_finished,
  output logic                           erase_finished
);
  import frbc_pkg::*;

  // ************************
  // State
  // ************************
  typedef struct packed {
    frbc_state_t      st;
    logic [3:0]       cnt;
    logic [TAG_W-1:0] rd_tag;
    logic             rd_pend;
    logic             wr_dp;
    logic [31:0]      addr_q;
    logic [127:0]     line0;
    logic [TAG_W-1:0] tag0;
    logic             v0;
    logic [127:0]     line1;
    logic [TAG_W-1:0] tag1;
    logic             v1;
    logic [127:0]     latch;
    logic [31:0]      hrdata;
    logic [31:0]      prdata;
    logic [1:0]       mode;
    logic             async_rd;
    logic             iss;
    logic [3:0]       read_wait_state_count;
    logic             init_done;
    logic             jtag_prot;
    logic [15:0]      sec_mask;
    logic             burn_busy;
    logic             erase_busy;
    logic             burn_start;
    logic             erase_start;
    logic             burn_evt;
    logic             erase_evt;
  } frbc_regs_t;

  frbc_regs_t             r;
  frbc_regs_t             next_r;
  logic                   acc;
  logic [TAG_W-1:0]       a_tag;
  logic                   hit0;
  logic                   hit1;
  logic                   apb_setup;
  logic                   apb_access;
  logic                   apb_hit;
  logic                   rd_done;
  logic                   inval;

  function automatic logic [31:0] word_of(input logic [127:0] l, input logic [1:0] s);
    return l[{s, 5'h00} +: 32];
  endfunction : word_of

  // Zero for reads of secured sections
  function automatic logic [31:0] guard(input logic [31:0] w, input logic [31:0] a,
                                        input logic [15:0] m);
    return m[a[SEC_REGION_LSB +: 4]] ? '0 : w;
  endfunction : guard

  // ************************
  // Decode
  // ************************
  assign acc        = ahb.hsel & ahb.htrans[1] & ahb.hready;
  assign a_tag      = ahb.haddr[31:WORD_LSB];
  // Index reads never hit so every index access reaches the array
  assign hit0       = r.v0 & (r.tag0 == a_tag) & (r.mode != MODE_NONE) & ~r.iss;
  assign hit1       = r.v1 & (r.tag1 == a_tag) & r.mode[1] & ~r.iss;
  assign apb_setup  = psel & ~penable;
  assign apb_access = psel & penable;
  assign apb_hit    = (paddr == FRBC_CFG_OFS) | (paddr == FRBC_STATUS_OFS) | (paddr == FRBC_CMD_OFS) |
                      (paddr == FRBC_SECURE_OFS) | (paddr == FRBC_LATCH_OFS);
  assign rd_done    = (r.st != ST_IDLE) & (r.cnt == '0);

  // ************************
  // Next state
  // ************************
  always_comb begin
    next_r = r;
    inval  = 1'b0;
    next_r.burn_start  = 1'b0;
    next_r.erase_start = 1'b0;
    next_r.burn_evt    = 1'b0;
    next_r.erase_evt   = 1'b0;
    if (r.st != ST_IDLE && r.cnt != '0) begin
      next_r.cnt = r.cnt - 4'h1;
    end
    // Write data phase fills the program latch
    if (r.wr_dp && hreadyout) begin
      next_r.latch[{r.addr_q[3:2], 5'h00} +: 32] = ahb.hwdata;
      next_r.wr_dp = 1'b0;
    end
    unique case (r.st)
      ST_INIT: begin
        if (rd_done) begin
          next_r.jtag_prot = flash_rsp.rdata[JTAG_PROT_BIT];
          next_r.sec_mask  = flash_rsp.rdata[SEC_MASK_LSB +: 16];
          next_r.init_done = 1'b1;
          inval            = 1'b1;
          if (r.rd_pend || (acc && !ahb.hwrite)) begin
            next_r.st     = ST_DEMAND;
            next_r.rd_tag = r.rd_pend ? r.addr_q[31:WORD_LSB] : a_tag;
            next_r.cnt    = r.read_wait_state_count;
          end else begin
            next_r.st = ST_IDLE;
          end
        end
      end
      ST_DEMAND: begin
        if (rd_done) begin
          next_r.rd_pend = 1'b0;
          next_r.hrdata  = guard(word_of(flash_rsp.rdata, r.addr_q[3:2]), r.addr_q, r.sec_mask);
          next_r.st      = ST_IDLE;
          if (r.iss) begin
            inval = 1'b1;
          end else if (r.mode[1] && r.async_rd) begin
            // Demand word parks in line 1, one prefetch follows
            next_r.line1 = flash_rsp.rdata;
            next_r.tag1  = r.rd_tag;
            next_r.v1    = 1'b1;
            next_r.v0    = 1'b0;
            next_r.st    = ST_SPEC;
            next_r.rd_tag = r.rd_tag + TAG_ONE;
            next_r.cnt   = r.read_wait_state_count;
          end else if (r.mode != MODE_NONE) begin
            next_r.line0 = flash_rsp.rdata;
            next_r.tag0  = r.rd_tag;
            next_r.v0    = 1'b1;
          end
        end
      end
      ST_SPEC: begin
        if (rd_done) begin
          next_r.st = ST_IDLE;
          if (!r.iss) begin
            next_r.line0 = flash_rsp.rdata;
            next_r.tag0  = r.rd_tag;
            next_r.v0    = 1'b1;
          end
        end
      end
      ST_IDLE: begin
      end
    endcase
    // AHB address phase
    if (acc && ahb.hwrite) begin
      next_r.addr_q = ahb.haddr;
      next_r.wr_dp  = 1'b1;
    end else if (acc) begin
      next_r.addr_q = ahb.haddr;
      if (!r.init_done) begin
        next_r.rd_pend = 1'b1;
      end else if (hit0 || hit1) begin
        next_r.hrdata = guard(word_of(hit0 ? r.line0 : r.line1, ahb.haddr[3:2]),
                              ahb.haddr, r.sec_mask);
        if (hit0 && r.mode[1]) begin
          next_r.line1  = r.line0;
          next_r.tag1   = r.tag0;
          next_r.v1     = 1'b1;
          next_r.v0     = 1'b0;
          next_r.st     = (r.mode == MODE_ALWAYS) ? ST_SPEC : next_r.st;
          next_r.rd_tag = r.tag0 + TAG_ONE;
          next_r.cnt    = r.read_wait_state_count;
        end
      end else if (r.st == ST_SPEC && a_tag == r.rd_tag) begin
        // Prefetch already running: the read stalls for the rest of its wait count
        next_r.rd_pend = 1'b1;
        next_r.st      = ST_DEMAND;
      end else begin
        // Running prefetch is dropped, only possible in async timing
        next_r.rd_pend = 1'b1;
        next_r.st      = ST_DEMAND;
        next_r.rd_tag  = a_tag;
        next_r.cnt     = r.read_wait_state_count;
      end
    end
    // APB register port
    if (apb_setup) begin
      next_r.prdata = '0;
      unique case (paddr)
        FRBC_CFG_OFS: begin
          next_r.prdata[CFG_MODE_LSB +: 2] = r.mode;
          next_r.prdata[CFG_ASYNC_BIT]     = r.async_rd;
          next_r.prdata[CFG_ISS_BIT]       = r.iss;
          next_r.prdata[CFG_WST_LSB +: 4]  = r.read_wait_state_count;
        end
        FRBC_STATUS_OFS: begin
          next_r.prdata[ST_INIT_BIT]  = r.init_done;
          next_r.prdata[ST_PROT_BIT]  = r.jtag_prot;
          next_r.prdata[ST_BURN_BIT]  = r.burn_busy;
          next_r.prdata[ST_ERASE_BIT] = r.erase_busy;
          next_r.prdata[ST_SPEC_BIT]  = (r.st == ST_SPEC);
        end
        FRBC_SECURE_OFS: next_r.prdata[15:0] = r.sec_mask;
        FRBC_LATCH_OFS:  next_r.prdata = r.latch[31:0];
        default:         next_r.prdata = '0;
      endcase
    end
    if (apb_access && paddr == FRBC_CFG_OFS) begin
      inval = 1'b1;
      if (pwrite) begin
        next_r.async_rd = pwdata[CFG_ASYNC_BIT];
        next_r.iss      = pwdata[CFG_ISS_BIT];
        next_r.read_wait_state_count      = pwdata[CFG_WST_LSB +: 4];
        next_r.mode     = (!pwdata[CFG_ASYNC_BIT] && pwdata[CFG_MODE_LSB + 1]) ?
                          MODE_SINGLE : pwdata[CFG_MODE_LSB +: 2];
      end
    end
    if (apb_access && !pwrite && paddr == FRBC_LATCH_OFS) begin
      inval = 1'b1;
    end
    // Commands while busy are ignored: no suspend path exists
    if (apb_access && pwrite && paddr == FRBC_CMD_OFS && !r.burn_busy && !r.erase_busy) begin
      if (pwdata[CMD_BURN_BIT]) begin
        next_r.burn_start = 1'b1;
        next_r.burn_busy  = 1'b1;
      end else if (pwdata[CMD_ERASE_BIT]) begin
        next_r.erase_start = 1'b1;
        next_r.erase_busy  = 1'b1;
      end
    end
    if (r.burn_busy && flash_rsp.burn_done) begin
      next_r.burn_busy = 1'b0;
      next_r.burn_evt  = 1'b1;
    end
    if (r.erase_busy && flash_rsp.erase_done) begin
      next_r.erase_busy = 1'b0;
      next_r.erase_evt  = 1'b1;
    end
    if (inval) begin
      next_r.v0 = 1'b0;
      next_r.v1 = 1'b0;
      next_r.st = (next_r.st == ST_SPEC) ? ST_IDLE : next_r.st;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r          <= '0;
      r.st       <= ST_INIT;
      r.cnt      <= INIT_WST;
      r.rd_tag   <= INDEX_TAG;
      r.mode     <= MODE_RESET;
      r.read_wait_state_count      <= WST_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ************************
  // Outputs
  // ************************
  assign prdata    = r.prdata;
  assign pready    = 1'b1;
  assign pslverr   = apb_access & ~apb_hit;
  assign hrdata    = r.hrdata;
  assign hreadyout = ~(r.rd_pend | (r.wr_dp & ~r.init_done));
  assign hresp     = HRESP_OKAY;
  assign flash_req.rd          = (r.st != ST_IDLE);
  assign flash_req.tag         = r.rd_tag;
  assign flash_req.index_sel   = r.iss | (r.st == ST_INIT);
  assign flash_req.standby     = ~r.async_rd & (r.st == ST_IDLE);
  assign flash_req.burn_start  = r.burn_start;
  assign flash_req.erase_start = r.erase_start;
  assign flash_req.wdata       = r.latch;
  assign jtag_grant = jtag_req & r.init_done & ~r.jtag_prot;
  assign debug_en   = r.init_done & ~r.jtag_prot;
  assign burn_finished  = r.burn_evt;
  assign erase_finished = r.erase_evt;

  // ************************
  // Assertions
  // ************************
  property p_init_stall;
    @(posedge pclk) disable iff (!presetn) (r.st == ST_INIT && r.rd_pend) |-> !hreadyout;
  endproperty
  a_init_stall: assert property (p_init_stall) else $error("read answered during init");
  property p_jtag_block;
    @(posedge pclk) disable iff (!presetn) r.jtag_prot |-> (!jtag_grant && !debug_en);
  endproperty
  a_jtag_block: assert property (p_jtag_block) else $error("jtag open while protected");
  property p_spec_async;
    @(posedge pclk) disable iff (!presetn) $rose(r.st == ST_SPEC) |-> $past(r.async_rd);
  endproperty
  a_spec_async: assert property (p_spec_async) else $error("prefetch in sync timing");
  property p_standby;
    @(posedge pclk) disable iff (!presetn)
      (!r.async_rd && r.st == ST_DEMAND && rd_done && !apb_access) |=> flash_req.standby;
  endproperty
  a_standby: assert property (p_standby) else $error("flash not in standby");
  property p_hit;
    @(posedge pclk) disable iff (!presetn) (acc && !ahb.hwrite && r.init_done && (hit0 || hit1)) |=> hreadyout;
  endproperty
  a_hit: assert property (p_hit) else $error("hit took wait state");
  property p_miss;
    @(posedge pclk) disable iff (!presetn) (acc && !ahb.hwrite && !hit0 && !hit1) |=> !hreadyout;
  endproperty
  a_miss: assert property (p_miss) else $error("miss answered without wait");
  property p_inval;
    @(posedge pclk) disable iff (!presetn) (apb_access && paddr == FRBC_CFG_OFS) |=> (!r.v0 && !r.v1);
  endproperty
  a_inval: assert property (p_inval) else $error("lines valid after config access");
  property p_burn_evt;
    @(posedge pclk) disable iff (!presetn) (r.burn_busy && flash_rsp.burn_done) |=> (burn_finished && !r.burn_busy);
  endproperty
  a_burn_evt: assert property (p_burn_evt) else $error("burn event missing");
  property p_no_dual_sync;
    @(posedge pclk) disable iff (!presetn) r.mode[1] |-> r.async_rd;
  endproperty
  a_no_dual_sync: assert property (p_no_dual_sync) else $error("dual mode in sync timing");
endmodule : frbc

// ==== frbc_flash_model.sv ====
// Purpose: Flash array model facing the read buffer controller
// Assumes: Read data settles once address is held ACC cycles
// Notes:   Unsettled data shows a moving pattern, never the old word
`timescale 1ns/1ps
module frbc_flash_model #(
  parameter int          ACC  = 1,
  parameter int          BUSY = 20,
  parameter logic [31:0] IDX  = 32'h0002_0000
)(
  // Clock, reset and index word protect bit
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                prot,
  // Array side
  input  frbc_pkg::frbc_flash_req_t req,
  output frbc_pkg::frbc_flash_rsp_t rsp
);
  import frbc_pkg::*;
  logic [TAG_W:0] last;
  logic [7:0]     held;
  logic [31:0]    noise;
  int             bcnt;
  int             ecnt;

  function automatic logic [127:0] word(logic [TAG_W-1:0] t);
    for (int l = 0; l < 4; l++) word[32*l +: 32] = {t[25:0], l[1:0], 4'ha};
  endfunction : word

  // ************************
  // Access time and program timing
  // ************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held  <= 8'h00;
      last  <= '0;
      noise <= 32'h1;
      bcnt  <= 0;
      ecnt  <= 0;
    end else begin
      last  <= {req.index_sel, req.tag};
      // A new address has stood one cycle by the first edge that sees it
      held  <= !req.rd ? 8'h00 : (({req.index_sel, req.tag} != last) ? 8'h01 :
               ((held < 8'hff) ? held + 8'h01 : held));
      noise <= {noise[30:0], noise[31] ^ noise[21] ^ noise[1] ^ noise[0]};
      // Burn and erase always run to completion
      bcnt  <= req.burn_start ? BUSY : ((bcnt > 0) ? bcnt - 1 : 0);
      ecnt  <= req.erase_start ? BUSY : ((ecnt > 0) ? ecnt - 1 : 0);
    end
  end

  always_comb begin
    rsp.rdata      = (held >= ACC) ? (req.index_sel ? {96'h0, IDX | {31'h0, prot}} : word(req.tag)) :
                     {4{noise}};
    rsp.burn_done  = (bcnt == 1);
    rsp.erase_done = (ecnt == 1);
  end
endmodule : frbc_flash_model

// ==== frbc_tb.sv ====
// Purpose: Self-checking bench of the flash read buffer controller
// Assumes: Flash model data valid one cycle after a held read
// Notes:   Buffer model tracks demand and prefetched flash words
`timescale 1ns/1ps
`define CHK(n,x,g) begin n_checks++; if ((g)!==(x)) begin mismatches++; $display("Error %s exp %h got %h",n,x,g); end end
module frbc_tb;
  import frbc_pkg::*;
  logic            pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata, hrdata, haddr, hwdata, seed;
  logic            hsel, hwrite, hreadyout, hresp, jtag_req, jtag_grant, debug_en;
  logic            burn_finished, erase_finished, prot;
  logic [1:0]      htrans;
  frbc_ahb_req_t   ahb;
  frbc_flash_req_t freq;
  frbc_flash_rsp_t frsp;
  int              mismatches, n_checks, last, pf, mode, async_m;

  assign ahb = {hsel, haddr, htrans, hwrite, hreadyout, hwdata};

  frbc frbc_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ahb(ahb),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .flash_req(freq), .flash_rsp(frsp),
    .jtag_req(jtag_req), .jtag_grant(jtag_grant), .debug_en(debug_en),
    .burn_finished(burn_finished), .erase_finished(erase_finished));

  frbc_flash_model frbc_flash_model_i (.pclk(pclk), .presetn(presetn), .prot(prot), .req(freq), .rsp(frsp));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // ************************
  // Verdict and helpers
  // ************************
  task automatic close_out;
    $display("Checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i == 50) begin
      mismatches++;
      close_out();
    end
    // Config access or latch read empties both lines
    if (a == FRBC_CFG_OFS || a == FRBC_LATCH_OFS) begin
      last = -1;
      pf = -1;
    end
  endtask : apb

  task automatic ahb_x(input logic wr, input int t, input int lane, input logic [31:0] d,
                       output logic [31:0] q, output int w);
    int i;
    seed = xs(seed);
    @(posedge pclk);
    hsel     <= 1'b1;
    htrans   <= 2'b10;
    hwrite   <= wr;
    haddr    <= {t[27:0], lane[1:0], 2'b00};
    jtag_req <= seed[7];
    @(posedge pclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    w = 0;
    for (i = 0; i < 200; i++) begin
      #1;
      if (hreadyout === 1'b1) break;
      w++;
      @(posedge pclk);
    end
    q = hrdata;
    if (i == 200) begin
      mismatches++;
      close_out();
    end
    @(posedge pclk);
  endtask : ahb_x

  // Read one word and compare with the buffer model
  task automatic rd(input int t, input int lane, output int w);
    logic [31:0] q;
    logic        hit;
    logic        sec;
    sec = (t[15:12] == 4'h1);
    hit = (mode != 0) && (t == last || (mode >= 2 && t == pf));
    ahb_x(1'b0, t, lane, 32'h0, q, w);
    `CHK("hrdata", sec ? 32'h0 : {t[25:0], lane[1:0], 4'ha}, q)
    `CHK("hresp", HRESP_OKAY, hresp)
    if (!sec) `CHK("zero_wait", hit, w == 0)
    if (mode == 3 || (mode == 2 && !hit)) pf = t + 1;
    else if (mode == 2 && t == pf) pf = -1;
    if (mode != 0) last = t;
    repeat (6) @(posedge pclk);
    #1;
    if (async_m == 0) `CHK("standby", 1'b1, freq.standby)
    `CHK("jtag_grant", jtag_req, jtag_grant)
    `CHK("debug_en", 1'b1, debug_en)
  endtask : rd

  // ************************
  // Main sequence
  // ************************
  initial begin
    logic [31:0] q;
    logic        e;
    int          w;
    int          base;
    {psel, penable, pwrite, hsel, hwrite, jtag_req, prot} = '0;
    paddr = '0;
    pwdata = '0;
    haddr = '0;
    htrans = '0;
    hwdata = '0;
    presetn = 1'b0;
    seed = 20283;
    {mismatches, n_checks} = '0;
    last = -1;
    pf = -1;
    mode = 1;
    async_m = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(32'h2000000, 0, w);
    `CHK("init_stall", 1'b1, w > 10)
    apb(1'b0, FRBC_STATUS_OFS, 32'h0, q, e);
    `CHK("init_done", 2'b01, q[1:0])
    apb(1'b0, FRBC_SECURE_OFS, 32'h0, q, e);
    `CHK("sec_mask", 16'h0002, q[15:0])
    apb(1'b0, FRBC_CFG_OFS, 32'h0, q, e);
    `CHK("cfg_reset", 32'h0000_00f1, q)
    apb(1'b0, 12'h0fc, 32'h0, q, e);
    `CHK("pslverr", 1'b1, e)
    for (int a = 0; a < 2; a++) begin
      for (int m = 0; m < 4; m++) begin
        apb(1'b1, FRBC_CFG_OFS, {24'h0, 4'h1, 1'b0, a[0], m[1:0]}, q, e);
        apb(1'b0, FRBC_CFG_OFS, 32'h0, q, e);
        mode = (a == 0 && m >= 2) ? 1 : m;
        async_m = a;
        `CHK("cfg_mode", mode[1:0], q[1:0])
        base = 32'h2000010 + m * 32 + a * 256;
        rd(base, 0, w);
        rd(base, 3, w);
        rd(base + 1, 1, w);
        rd(base + 2, 2, w);
        repeat (6) begin
          seed = xs(seed);
          rd(base + seed[1:0], seed[5:4], w);
        end
        rd(base + 32'h1000, 0, w);
      end
    end
    apb(1'b1, FRBC_CFG_OFS, 32'h0000_0019, q, e);
    ahb_x(1'b0, 32'h2000000, 0, 32'h0, q, w);
    `CHK("index_word", 32'h0002_0000, q)
    apb(1'b1, FRBC_CFG_OFS, 32'h0000_0011, q, e);
    mode = 1;
    async_m = 0;
    rd(32'h2000040, 0, w);
    ahb_x(1'b1, 32'h2000040, 0, 32'h5a3c_0f96, q, w);
    `CHK("write_wait", 0, w)
    apb(1'b0, FRBC_LATCH_OFS, 32'h0, q, e);
    `CHK("latch", 32'h5a3c_0f96, q)
    rd(32'h2000040, 2, w);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, FRBC_CMD_OFS, 32'h1 << k, q, e);
      apb(1'b0, FRBC_STATUS_OFS, 32'h0, q, e);
      `CHK("busy", 1'b1, q[ST_BURN_BIT + k])
      for (w = 0; w < 100; w++) begin
        @(posedge pclk);
        #1;
        if ((k ? erase_finished : burn_finished) === 1'b1) break;
      end
      `CHK("finished", 1'b1, w < 100)
    end
    // Second reset with a protected index word
    @(posedge pclk);
    presetn <= 1'b0;
    prot    <= 1'b1;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    base = 32'h2000050;
    ahb_x(1'b0, base, 1, 32'h0, q, w);
    `CHK("prot_stall", 1'b1, w > 10)
    `CHK("prot_data", {base[25:0], 2'h1, 4'ha}, q)
    jtag_req <= 1'b1;
    @(posedge pclk);
    #1;
    `CHK("prot_grant", 1'b0, jtag_grant)
    `CHK("prot_debug", 1'b0, debug_en)
    apb(1'b0, FRBC_STATUS_OFS, 32'h0, q, e);
    `CHK("prot_status", 2'b11, q[1:0])
    close_out();
  end
endmodule : frbc_tb
